// File: core/ais_pkg.sv
package ais_pkg;

   // ***************************************************
   // register map (word addresses of the serial protocol)
   // ***************************************************
   localparam logic [15:0] ADDR_IN1_RANGE  = 16'h0410;
   localparam logic [15:0] ADDR_IN1_GAIN   = 16'h0411;
   localparam logic [15:0] ADDR_IN1_BIAS   = 16'h0412;
   localparam logic [15:0] ADDR_IN3_RANGE  = 16'h0413;
   localparam logic [15:0] ADDR_IN3_FUNC   = 16'h0414;
   localparam logic [15:0] ADDR_IN3_GAIN   = 16'h0415;
   localparam logic [15:0] ADDR_IN3_BIAS   = 16'h0416;
   localparam logic [15:0] ADDR_IN2_RANGE  = 16'h0417;

   // ***************************************************
   // limits and values after reset, gains and biases in 0.1 percent units
   // ***************************************************
   localparam logic [15:0] RANGE13_MAX     = 16'h0001;
   localparam logic [15:0] RANGE2_MAX      = 16'h0002;
   localparam logic [15:0] FUNC_MAX        = 16'h001f;
   localparam logic [15:0] GAIN_MAX        = 16'h2710;   // 1000.0 percent
   localparam logic [15:0] BIAS_MAX        = 16'h03e8;   // +100.0 percent
   localparam logic [15:0] BIAS_MIN        = 16'hfc18;   // -100.0 percent
   localparam logic [15:0] RST_RANGE13     = 16'h0000;
   localparam logic [15:0] RST_RANGE2      = 16'h0002;
   localparam logic [15:0] RST_FUNC        = 16'h0002;
   localparam logic [15:0] RST_GAIN        = 16'h03e8;   // 100.0 percent
   localparam logic [15:0] RST_BIAS        = 16'h0000;

   // ***************************************************
   // converter sample layout and scaling
   // ***************************************************
   localparam int          MAG_W           = 11;
   localparam int          FS_SHIFT        = 11;         // 2048 counts stand for 10 V
   localparam int          SCALE_LAT       = 1;          // cycles from sample to level

   typedef struct packed {
      logic             neg;                             // polarity, used when bipolar
      logic [10:0]      mag;
   } ais_sample_t;

   typedef struct packed {
      logic             wr;
      logic             rd;
      logic [15:0]      addr;
      logic [15:0]      wdata;
   } ais_req_t;

   typedef struct packed {
      logic             ack;
      logic             err;
      logic [15:0]      rdata;
   } ais_rsp_t;

endpackage

// File: core/ais_scale.sv
module ais_scale (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               bipolar,
   input  wire logic [15:0]        gain,
   input  wire logic [15:0]        bias,
   input  wire ais_pkg::ais_sample_t sample,
   output logic signed [15:0]      level
);
   import ais_pkg::*;

   logic        [26:0] prod;
   logic        [15:0] span;
   logic signed [16:0] sum;
   logic signed [15:0] level_d;

   // ***************************************************
   // bias plus gain times fraction of full scale
   // ***************************************************
   // truncating shift keeps the slope exact at the cost of a tiny low-end bias
   always_comb begin
      prod    = 27'(gain) * 27'(sample.mag);
      span    = prod[26:FS_SHIFT];
      if (bipolar && sample.neg) begin
         sum = 17'($signed(bias)) - 17'($signed({1'b0, span}));
      end else begin
         sum = 17'($signed(bias)) + 17'($signed({1'b0, span}));
      end
      level_d = sum[15:0];                               // limits keep |sum| under 11100
   end

   // registered level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level <= 16'sh0000;
      end else begin
         level <= level_d;
      end
   end

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_ZERO_GIVES_BIAS: assert property (
      sample.mag == 11'h000 |=> level == $signed($past(bias)))
      else $error("zero input does not give bias");
   AST_UNIPOLAR_ABOVE_BIAS: assert property (
      !bipolar && gain <= GAIN_MAX |=> level >= $signed($past(bias)))
      else $error("unipolar level fell below bias");
   AST_NEG_BELOW_BIAS: assert property (
      bipolar && sample.neg && gain <= GAIN_MAX |=> level <= $signed($past(bias)))
      else $error("negative bipolar input rose above bias");
endmodule

// File: core/ais_top.sv
module ais_top (
   input  wire logic                 ref_clk,
   input  wire logic                 nrst,
   input  wire logic                 drive_running,
   input  wire ais_pkg::ais_req_t    reg_req,
   output ais_pkg::ais_rsp_t         reg_rsp,
   input  wire ais_pkg::ais_sample_t first_analog_input,
   input  wire ais_pkg::ais_sample_t third_analog_input,
   output logic signed [15:0]        input1_level,
   output logic signed [15:0]        input3_level,
   output logic [4:0]                input3_function,
   output logic [1:0]                input2_signal_type
);
   import ais_pkg::*;

   // ***************************************************
   // reset release
   // ***************************************************
   logic [1:0] rst_sync_q;
   logic       rst_n;

   // release through two stages so the rest sees a clean edge
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ***************************************************
   // parameter registers
   // ***************************************************
   logic        in1_range_q;
   logic [15:0] in1_gain_q;
   logic [15:0] in1_bias_q;
   logic        in3_range_q;
   logic [4:0]  in3_func_q;
   logic [15:0] in3_gain_q;
   logic [15:0] in3_bias_q;
   logic [1:0]  in2_range_q;

   logic        wr_legal;
   logic        wr_refused;
   logic        rd_hit;
   logic [15:0] rd_val;
   logic        gain_ok;
   logic        bias_ok;

   // value checks for the incoming write data
   assign gain_ok = reg_req.wdata <= GAIN_MAX;
   assign bias_ok = $signed(reg_req.wdata) >= $signed(BIAS_MIN)
                 && $signed(reg_req.wdata) <= $signed(BIAS_MAX);

   // decide whether a write may land; static settings lock while running
   always_comb begin
      wr_legal = 1'b0;
      case (reg_req.addr)
         ADDR_IN1_RANGE,
         ADDR_IN3_RANGE: wr_legal = !drive_running && reg_req.wdata <= RANGE13_MAX;
         ADDR_IN3_FUNC:  wr_legal = !drive_running && reg_req.wdata <= FUNC_MAX;
         ADDR_IN2_RANGE: wr_legal = !drive_running && reg_req.wdata <= RANGE2_MAX;
         ADDR_IN1_GAIN,
         ADDR_IN3_GAIN:  wr_legal = gain_ok;
         ADDR_IN1_BIAS,
         ADDR_IN3_BIAS:  wr_legal = bias_ok;
         default:        wr_legal = 1'b0;
      endcase
   end
   assign wr_refused = reg_req.wr && !wr_legal;

   // range selects, input1 and input3 reset to unipolar, input2 to code 2
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         in1_range_q <= RST_RANGE13[0];
         in3_range_q <= RST_RANGE13[0];
         in2_range_q <= RST_RANGE2[1:0];
      end else if (reg_req.wr && wr_legal) begin
         if (reg_req.addr == ADDR_IN1_RANGE) begin
            in1_range_q <= reg_req.wdata[0];
         end
         if (reg_req.addr == ADDR_IN3_RANGE) begin
            in3_range_q <= reg_req.wdata[0];
         end
         if (reg_req.addr == ADDR_IN2_RANGE) begin
            in2_range_q <= reg_req.wdata[1:0];
         end
      end
   end

   // function code of input3
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         in3_func_q <= RST_FUNC[4:0];
      end else if (reg_req.wr && wr_legal && reg_req.addr == ADDR_IN3_FUNC) begin
         in3_func_q <= reg_req.wdata[4:0];
      end
   end

   // gains and biases, accepted at any time
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         in1_gain_q <= RST_GAIN;
         in1_bias_q <= RST_BIAS;
         in3_gain_q <= RST_GAIN;
         in3_bias_q <= RST_BIAS;
      end else if (reg_req.wr && wr_legal) begin
         case (reg_req.addr)
            ADDR_IN1_GAIN: in1_gain_q <= reg_req.wdata;
            ADDR_IN1_BIAS: in1_bias_q <= reg_req.wdata;
            ADDR_IN3_GAIN: in3_gain_q <= reg_req.wdata;
            ADDR_IN3_BIAS: in3_bias_q <= reg_req.wdata;
            default: ;
         endcase
      end
   end

   // ***************************************************
   // read path and answer
   // ***************************************************
   // read mux, narrow fields zero-extended
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 16'h0000;
      case (reg_req.addr)
         ADDR_IN1_RANGE: rd_val = {15'h0000, in1_range_q};
         ADDR_IN1_GAIN:  rd_val = in1_gain_q;
         ADDR_IN1_BIAS:  rd_val = in1_bias_q;
         ADDR_IN3_RANGE: rd_val = {15'h0000, in3_range_q};
         ADDR_IN3_FUNC:  rd_val = {11'h000, in3_func_q};
         ADDR_IN3_GAIN:  rd_val = in3_gain_q;
         ADDR_IN3_BIAS:  rd_val = in3_bias_q;
         ADDR_IN2_RANGE: rd_val = {14'h0000, in2_range_q};
         default:        rd_hit = 1'b0;
      endcase
   end

   // one answer per request, one cycle later; write wins if both strobes set
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rsp <= '0;
      end else begin
         reg_rsp.ack   <= reg_req.wr || reg_req.rd;
         reg_rsp.err   <= reg_req.wr ? wr_refused : (reg_req.rd && !rd_hit);
         reg_rsp.rdata <= (reg_req.rd && !reg_req.wr && rd_hit) ? rd_val : 16'h0000;
      end
   end

   // ***************************************************
   // scaling channels
   // ***************************************************
   ais_scale u_scale1 (
      .clk     (ref_clk),
      .rst_n   (rst_n),
      .bipolar (in1_range_q),
      .gain    (in1_gain_q),
      .bias    (in1_bias_q),
      .sample  (first_analog_input),
      .level   (input1_level)
   );

   ais_scale u_scale3 (
      .clk     (ref_clk),
      .rst_n   (rst_n),
      .bipolar (in3_range_q),
      .gain    (in3_gain_q),
      .bias    (in3_bias_q),
      .sample  (third_analog_input),
      .level   (input3_level)
   );

   assign input3_function    = in3_func_q;
   assign input2_signal_type = in2_range_q;

   // ***************************************************
   // checks
   // ***************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_locked_write;
      reg_req.wr && drive_running
      && (reg_req.addr == ADDR_IN1_RANGE || reg_req.addr == ADDR_IN3_RANGE
          || reg_req.addr == ADDR_IN3_FUNC || reg_req.addr == ADDR_IN2_RANGE);
   endsequence

   sequence s_refused_answer;
      reg_rsp.ack && reg_rsp.err;
   endsequence

   AST_LOCKED_WRITE_REFUSED: assert property (
      s_locked_write |=> s_refused_answer and ($stable(in1_range_q)
         && $stable(in3_range_q) && $stable(in3_func_q) && $stable(in2_range_q)))
      else $error("static setting changed while running");
   AST_GAIN_WHILE_RUNNING: assert property (
      reg_req.wr && drive_running && reg_req.addr == ADDR_IN1_GAIN && gain_ok
      |=> in1_gain_q == $past(reg_req.wdata) && !reg_rsp.err)
      else $error("gain write while running was lost");
   AST_RANGE1_LEGAL: assert property (
      reg_req.wr && !drive_running && reg_req.addr == ADDR_IN1_RANGE
      && reg_req.wdata > RANGE13_MAX |=> $stable(in1_range_q) ##0 s_refused_answer)
      else $error("illegal range code accepted");
   AST_GAIN1_LIMIT: assert property (in1_gain_q <= GAIN_MAX)
      else $error("input1 gain above limit");
   AST_BIAS1_LIMIT: assert property (
      $signed(in1_bias_q) >= $signed(BIAS_MIN) && $signed(in1_bias_q) <= $signed(BIAS_MAX))
      else $error("input1 bias out of limit");
   AST_GAIN3_LIMIT: assert property (in3_gain_q <= GAIN_MAX)
      else $error("input3 gain above limit");
   AST_BIAS3_LIMIT: assert property (
      $signed(in3_bias_q) >= $signed(BIAS_MIN) && $signed(in3_bias_q) <= $signed(BIAS_MAX))
      else $error("input3 bias out of limit");
   AST_FUNC_WRITE: assert property (
      reg_req.wr && !drive_running && reg_req.addr == ADDR_IN3_FUNC
      && reg_req.wdata <= FUNC_MAX |=> in3_func_q == $past(reg_req.wdata[4:0]))
      else $error("legal function code not stored");
   AST_IN2_LEGAL: assert property (in2_range_q <= RANGE2_MAX[1:0])
      else $error("input2 range code illegal");
endmodule

// File: tb/ais_src.sv
module ais_src (
   input  wire logic               ref_clk,
   input  wire logic signed [15:0] mv_req,
   output ais_pkg::ais_sample_t    sample
);
   timeunit 1ns;
   timeprecision 1ns;
   import ais_pkg::*;
   logic [15:0] mv_abs;
   logic [31:0] counts;
   // voltage in millivolts turned into counts, 2048 counts for 10 V
   always_comb begin
      mv_abs = mv_req[15] ? 16'(-mv_req) : mv_req;
      counts = (32'(mv_abs) * 32'd2048) / 32'd10000;
   end
   // one conversion per clock; clipped, since 10 V itself has no code of its own
   always_ff @(posedge ref_clk) begin
      sample.neg <= mv_req[15];
      sample.mag <= (counts > 32'd2047) ? 11'h7ff : counts[10:0];
   end
endmodule

// File: tb/tb_analog_input_scaling.sv
module tb_analog_input_scaling;
   timeunit 1ns;
   timeprecision 1ns;
   import ais_pkg::*;
   logic               ref_clk = 1'b0;
   logic               nrst;
   logic               drive_running;
   ais_req_t           reg_req;
   ais_rsp_t           reg_rsp;
   logic signed [15:0] mv1, mv3;
   ais_sample_t        s1, s3;
   logic signed [15:0] input1_level, input3_level;
   logic [4:0]         input3_function;
   logic [1:0]         input2_signal_type;
   int                 error_cnt, checks_done, i, g, b, v1, v3;
   logic               bp;
   // shadow of the register file, starting from the reset values
   logic [15:0]        shadow [8] = '{16'h0, 16'h3e8, 16'h0, 16'h0, 16'h2, 16'h3e8, 16'h0, 16'h2};
   // address, value, refused
   logic [32:0]        tbl [17] = '{{16'h410, 16'h1, 1'b0}, {16'h410, 16'h2, 1'b1},
      {16'h413, 16'h1, 1'b0}, {16'h413, 16'h2, 1'b1}, {16'h414, 16'h1f, 1'b0},
      {16'h414, 16'h20, 1'b1}, {16'h417, 16'h0, 1'b0}, {16'h417, 16'h3, 1'b1},
      {16'h411, 16'h2710, 1'b0}, {16'h411, 16'h2711, 1'b1}, {16'h412, 16'h3e8, 1'b0},
      {16'h412, 16'hfc18, 1'b0}, {16'h412, 16'h3e9, 1'b1}, {16'h412, 16'hfc17, 1'b1},
      {16'h415, 16'h0, 1'b0}, {16'h416, 16'hfc17, 1'b1}, {16'h418, 16'h5, 1'b1}};

   always #25 ref_clk = ~ref_clk;

   ais_src src1 (.ref_clk(ref_clk), .mv_req(mv1), .sample(s1));
   ais_src src3 (.ref_clk(ref_clk), .mv_req(mv3), .sample(s3));
   ais_top uut (.ref_clk(ref_clk), .nrst(nrst), .drive_running(drive_running),
      .reg_req(reg_req), .reg_rsp(reg_rsp), .first_analog_input(s1),
      .third_analog_input(s3), .input1_level(input1_level), .input3_level(input3_level),
      .input3_function(input3_function), .input2_signal_type(input2_signal_type));

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one register cycle: strobe for one clock, answer looked at in its one cycle
   task automatic bus(input logic w, input logic [15:0] a, d, x, input logic e);
      @(posedge ref_clk);
      reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge ref_clk);
      reg_req <= '0;
      #1;
      chk("ack", 16'h1, 16'(reg_rsp.ack));
      chk("err", 16'(e), 16'(reg_rsp.err));
      if (!w) chk("rdata", x, reg_rsp.rdata);
   endtask

   // level from settings and millivolts, truncating the product toward zero
   function automatic logic [15:0] want(input int gn, bs, mv, input logic bip);
      int m, p;
      m = ((mv < 0) ? -mv : mv) * 2048 / 10000;
      if (m > 2047) m = 2047;
      p = (gn * m) >>> 11;
      return 16'(bs + ((bip && mv < 0) ? -p : p));
   endfunction

   // input3 runs in the other mode with mirrored settings
   task automatic scale(input int gn, bs, va, vb, input logic bip);
      bus(1'b1, ADDR_IN1_GAIN, 16'(gn), 16'h0, 1'b0);
      bus(1'b1, ADDR_IN1_BIAS, 16'(bs), 16'h0, 1'b0);
      bus(1'b1, ADDR_IN1_RANGE, 16'(bip), 16'h0, 1'b0);
      bus(1'b1, ADDR_IN3_GAIN, 16'(10000 - gn), 16'h0, 1'b0);
      bus(1'b1, ADDR_IN3_BIAS, 16'(-bs), 16'h0, 1'b0);
      bus(1'b1, ADDR_IN3_RANGE, 16'(!bip), 16'h0, 1'b0);
      mv1 <= 16'(va);
      mv3 <= 16'(vb);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("input1_level", want(gn, bs, va, bip), input1_level);
      chk("input3_level", want(10000 - gn, -bs, vb, !bip), input3_level);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard at 20000 cycles, well beyond the roughly 820 cycles the tests need
   initial begin
      #(50 * 20000);
      error_cnt++;
      $display("watchdog expired");
      complete_run();
   end

   initial begin
      nrst = 1'b0;
      drive_running = 1'b0;
      reg_req = '0;
      mv1 = '0;
      mv3 = '0;
      error_cnt = 0;
      checks_done = 0;
      void'($urandom(56));
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (i = 0; i < 8; i++) bus(1'b0, 16'(16'h410 + i), 16'h0, shadow[i], 1'b0);
      chk("input3_function", 16'h2, 16'(input3_function));
      chk("input1_level", 16'h0, input1_level);
      $display("test reset values done");
      foreach (tbl[j]) begin
         bus(1'b1, tbl[j][32:17], tbl[j][16:1], 16'h0, tbl[j][0]);
         if (!tbl[j][0]) shadow[3'(tbl[j][32:17])] = tbl[j][16:1];
         bus(1'b0, tbl[j][32:17], 16'h0, (tbl[j][32:17] == 16'h418) ? 16'h0 : shadow[3'(tbl[j][32:17])], tbl[j][32:17] == 16'h418);
      end
      chk("input2_signal_type", 16'h0, 16'(input2_signal_type));
      $display("test limits done");
      for (i = 0; i < 32; i++) begin
         bus(1'b1, ADDR_IN3_FUNC, 16'(i), 16'h0, 1'b0);
         chk("input3_function", 16'(i), 16'(input3_function));
      end
      $display("test function codes done");
      @(posedge ref_clk);
      drive_running <= 1'b1;
      for (i = 0; i < 8; i++) bus(1'b1, 16'(16'h410 + i), 16'h1, 16'h0, !(i inside {1, 2, 5, 6}));
      bus(1'b0, ADDR_IN3_FUNC, 16'h0, 16'h1f, 1'b0);
      bus(1'b0, ADDR_IN1_GAIN, 16'h0, 16'h1, 1'b0);
      @(posedge ref_clk);
      drive_running <= 1'b0;
      $display("test running lock done");
      scale(1000, 0, 5000, 5000, 1'b0);
      scale(10000, 1000, -10000, 10000, 1'b1);
      scale(0, -1000, 0, -10000, 1'b0);
      for (i = 0; i < 40; i++) begin
         bp = 1'($urandom_range(1));
         g = $urandom_range(10000);
         b = int'($urandom_range(2000)) - 1000;
         v1 = bp ? int'($urandom_range(20000)) - 10000 : int'($urandom_range(10000));
         v3 = bp ? int'($urandom_range(10000)) : int'($urandom_range(20000)) - 10000;
         scale(g, b, v1, v3, bp);
      end
      $display("test scaling done");
      complete_run();
   end
endmodule
